// [ioc_defs.svh]
// Purpose: shared constants of the i/o processor channel controller
// Assumes: 18-bit words, 25 MHz ref_clk, 1 us nominal processor cycle
// Notes:   bit numbers of the instruction word count from the lsb (bit 0 = lsb)
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH

`define IOC_W           18
`define IOC_SEL_W       8
`define IOC_CMD_W       4
`define IOC_CYC_NS      1000
`define IOC_CLK_NS      40
`define IOC_CYC_CLKS    ((`IOC_CYC_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)
`define IOC_CYC_CW      5
`define IOC_RTC_ADDR    18'h00007
`define IOC_OP_VAL      6'h38
`define IOC_OP_HI       17
`define IOC_OP_LO       12
`define IOC_SEL_HI      11
`define IOC_SEL_LO      4
`define IOC_CMD_HI      3
`define IOC_CMD_LO      0
`define IOC_CMD_CLR     3
`define IOC_CMD_OUT     2
`define IOC_CMD_IN      1
`define IOC_CMD_FLAG    0

`endif

// [ioc_pkg.sv]
// Purpose: types of the i/o processor channel controller
// Assumes: nothing beyond ioc_defs.svh
// Notes:   state codes are binary and fixed
package ioc_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_MULTI  = 2'h1,
    MODE_INCR   = 2'h2,
    MODE_ADD    = 2'h3
  } ioc_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_GRANT  = 4'h1,
    ST_TAKE   = 4'h2,
    ST_WCNT   = 4'h3,
    ST_CPTR   = 4'h4,
    ST_DATA   = 4'h5,
    ST_SETTLE = 4'h6,
    ST_ADDW   = 4'h7,
    ST_RET    = 4'h8,
    ST_ET1    = 4'h9,
    ST_ET2    = 4'hA,
    ST_ET3    = 4'hB
  } ioc_state_t;

  typedef enum logic [2:0] {
    PH_START = 3'h0,
    PH_RD    = 3'h1,
    PH_CALC  = 3'h2,
    PH_WR    = 3'h3,
    PH_DONE  = 3'h4
  } ioc_memph_t;

endpackage

// [ioc_add_if.sv]
// Purpose: operand and result lines of the channel adder
// Assumes: combinational adder
// Notes:   inh passes operand a through unchanged
`timescale 1ns/100ps
interface ioc_add_if #(parameter int W = 18);
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic         inh;
  logic [W-1:0] sum;
  logic         carry;
  modport user (output a, output b, output inh, input sum, input carry);
  modport calc (input a, input b, input inh, output sum, output carry);
endinterface

// [ioc_adder.sv]
// Purpose: channel adder with inhibit and overflow
// Assumes: purely combinational
// Notes:   carry marks an all-ones word rolling over to zero on increment
`timescale 1ns/100ps
module ioc_adder #(
  parameter int W = 18
) (
  // operands and result
  ioc_add_if.calc port
);
  always_comb begin
    if (port.inh) begin
      {port.carry, port.sum} = {1'b0, port.a};
    end else begin
      {port.carry, port.sum} = {1'b0, port.a} + {1'b0, port.b};
    end
  end
endmodule

// [ioc_channel_ctrl.sv]
// Purpose: i/o processor block channel control and transfer instruction sequencer
// Assumes: ioc_defs.svh included; memory answers each request with one memAck
// Notes:
`timescale 1ns/100ps
`include "ioc_defs.svh"
module ioc_channel_ctrl #(
  parameter int W = `IOC_W
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // channel request side
  input  wire logic                chanReq,
  input  wire ioc_pkg::ioc_mode_t  chanMode,
  input  wire logic                chanOut,
  output logic                     chanGrant_q,
  output logic                     ovflPulse_q,
  // shared bus lines
  input  wire logic [W-1:0]        busAddrIn,
  input  wire logic [W-1:0]        busDataIn,
  output logic [W-1:0]             busDataOut_q,
  output logic                     busDataOe_q,
  // memory switch
  output logic                     memReq_q,
  output logic                     memWe_q,
  output logic [W-1:0]             memAddr_q,
  output logic [W-1:0]             memWdata_q,
  output logic                     cpuLockout_q,
  input  wire logic                memAck,
  input  wire logic [W-1:0]        memRdata,
  // real-time clock
  input  wire logic                rtcEnable,
  input  wire logic                rtcTick,
  output logic                     rtcIntReq_q,
  // transfer instructions
  input  wire logic                iotValid,
  input  wire logic [W-1:0]        iotWord,
  input  wire logic [W-1:0]        accIn,
  output logic [`IOC_SEL_W-1:0]    devSelect_q,
  output logic                     devSelActive_q,
  output logic                     accClear_q,
  output logic                     flagTestPulse_q,
  output logic                     inputStrobePulse_q,
  output logic                     outputStrobePulse_q,
  output logic                     accWrite_q,
  output logic [W-1:0]             accData_q,
  output logic                     iotDone_q
);
  import ioc_pkg::*;

  localparam logic [`IOC_CYC_CW-1:0] CycLast = `IOC_CYC_CW'(`IOC_CYC_CLKS - 1);

  ioc_state_t             state_q;
  ioc_state_t             state_d;
  ioc_state_t             endState;
  ioc_memph_t             memPh_q;
  ioc_mode_t              mode_q;
  logic [`IOC_CYC_CW-1:0] cyc_q;
  logic                   dirOut_q;
  logic                   srcRtc_q;
  logic [W-1:0]           dsr_q;
  logic [W-1:0]           caPtr_q;
  logic [W-1:0]           mbr_q;
  logic [W-1:0]           rd_q;
  logic [W-1:0]           takenAddr_q;
  logic [`IOC_SEL_W-1:0]  sel_q;
  logic [`IOC_CMD_W-1:0]  cmd_q;
  logic                   iotPend_q;
  logic                   rtcPend_q;
  logic                   tickPrev_q;
  logic                   needRd;
  logic                   needWr;
  logic [W-1:0]           opAddr;
  logic [W-1:0]           wData;
  logic                   stepDone;
  logic                   isSkip;

  ioc_add_if #(.W(W)) addBus ();
  ioc_adder #(.W(W)) uAdder (
    .port (addBus.calc)
  );

  assign stepDone = (memPh_q == PH_DONE) && (cyc_q == CycLast);
  assign isSkip   = !cmd_q[`IOC_CMD_OUT] && !cmd_q[`IOC_CMD_IN];
  // burst when the device still holds its request after a word
  assign endState = (!srcRtc_q && chanReq) ? ST_GRANT : ST_IDLE;

  // per-state memory operation and adder steering
  always_comb begin
    needRd     = 1'b0;
    needWr     = 1'b0;
    opAddr     = dsr_q;
    addBus.a   = rd_q;
    addBus.b   = W'(1);
    addBus.inh = 1'b0;
    wData      = addBus.sum;
    case (state_q)
      ST_TAKE: begin
        addBus.a   = busAddrIn;
        addBus.inh = 1'b1;
      end
      ST_WCNT: begin
        needRd = 1'b1;
        needWr = 1'b1;
      end
      ST_CPTR: begin
        needRd = 1'b1;
        needWr = 1'b1;
        if (memPh_q == PH_START) begin
          addBus.a = dsr_q;
          opAddr   = addBus.sum;
        end
      end
      ST_DATA: begin
        needRd = dirOut_q;
        needWr = !dirOut_q;
        opAddr = caPtr_q;
        wData  = mbr_q;
      end
      ST_ADDW: begin
        needRd   = 1'b1;
        needWr   = 1'b1;
        opAddr   = caPtr_q;
        addBus.b = mbr_q;
      end
      default: begin
      end
    endcase
  end

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (chanReq) begin
          state_d = ST_GRANT;
        end else if (rtcPend_q) begin
          state_d = ST_WCNT;
        end else if (iotPend_q) begin
          state_d = ST_ET1;
        end
      end
      ST_GRANT: state_d = ST_TAKE;
      ST_TAKE: state_d = (mode_q == MODE_SINGLE) ? ST_DATA : ST_WCNT;
      ST_WCNT: begin
        if (stepDone) begin
          state_d = (mode_q == MODE_INCR) ? endState : ST_CPTR;
        end
      end
      ST_CPTR: begin
        if (stepDone) begin
          state_d = (mode_q == MODE_ADD) ? ST_ADDW : ST_DATA;
        end
      end
      ST_DATA: begin
        if (stepDone) begin
          state_d = (mode_q == MODE_MULTI && dirOut_q) ? ST_SETTLE : endState;
        end
      end
      ST_SETTLE: state_d = stepDone ? endState : ST_SETTLE;
      ST_ADDW: state_d = stepDone ? ST_RET : ST_ADDW;
      ST_RET: state_d = stepDone ? endState : ST_RET;
      ST_ET1: begin
        if (stepDone) begin
          state_d = isSkip ? ST_IDLE : ST_ET2;
        end
      end
      ST_ET2: state_d = stepDone ? ST_ET3 : ST_ET2;
      ST_ET3: state_d = stepDone ? ST_IDLE : ST_ET3;
      default: state_d = ST_IDLE;
    endcase
  end

  // state and processor cycle timer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cyc_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        cyc_q <= '0;
      end else if (cyc_q != CycLast) begin
        cyc_q <= cyc_q + `IOC_CYC_CW'(1);
      end
    end
  end

  // memory engine: read, modify, write within one processor cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      memPh_q    <= PH_START;
      memReq_q   <= 1'b0;
      memWe_q    <= 1'b0;
      memAddr_q  <= '0;
      memWdata_q <= '0;
      rd_q       <= '0;
    end else if (state_d != state_q) begin
      memPh_q  <= PH_START;
      memReq_q <= 1'b0;
    end else begin
      case (memPh_q)
        PH_START: begin
          if (needRd) begin
            memReq_q  <= 1'b1;
            memWe_q   <= 1'b0;
            memAddr_q <= opAddr;
            memPh_q   <= PH_RD;
          end else if (needWr) begin
            memReq_q   <= 1'b1;
            memWe_q    <= 1'b1;
            memAddr_q  <= opAddr;
            memWdata_q <= wData;
            memPh_q    <= PH_WR;
          end else begin
            memPh_q <= PH_DONE;
          end
        end
        PH_RD: begin
          if (memAck) begin
            memReq_q <= 1'b0;
            rd_q     <= memRdata;
            memPh_q  <= needWr ? PH_CALC : PH_DONE;
          end
        end
        PH_CALC: begin
          memReq_q   <= 1'b1;
          memWe_q    <= 1'b1;
          memAddr_q  <= opAddr;
          memWdata_q <= wData;
          memPh_q    <= PH_WR;
        end
        PH_WR: begin
          if (memAck) begin
            memReq_q <= 1'b0;
            memPh_q  <= PH_DONE;
          end
        end
        default: memPh_q <= PH_DONE;
      endcase
    end
  end

  // channel datapath registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q      <= MODE_SINGLE;
      dirOut_q    <= 1'b0;
      srcRtc_q    <= 1'b0;
      dsr_q       <= '0;
      caPtr_q     <= '0;
      mbr_q       <= '0;
      takenAddr_q <= '0;
    end else begin
      if (state_d == ST_GRANT && state_q != ST_GRANT) begin
        mode_q   <= chanMode;
        dirOut_q <= chanOut;
        srcRtc_q <= 1'b0;
      end else if (state_q == ST_IDLE && state_d == ST_WCNT) begin
        mode_q   <= MODE_INCR;
        srcRtc_q <= 1'b1;
        dsr_q    <= `IOC_RTC_ADDR;
      end
      if (state_q == ST_TAKE) begin
        dsr_q       <= addBus.sum;
        caPtr_q     <= addBus.sum;
        mbr_q       <= busDataIn;
        takenAddr_q <= busAddrIn;
      end
      if (state_q == ST_CPTR && memPh_q == PH_START && state_d == ST_CPTR) begin
        dsr_q <= addBus.sum;
      end
      if (state_q == ST_CPTR && memPh_q == PH_CALC) begin
        caPtr_q <= addBus.sum;
      end
      if (state_q == ST_ADDW && memPh_q == PH_CALC) begin
        mbr_q <= addBus.sum;
      end
    end
  end

  // tally overflow pulses
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ovflPulse_q <= 1'b0;
      rtcIntReq_q <= 1'b0;
    end else begin
      ovflPulse_q <= state_q == ST_WCNT && memPh_q == PH_CALC && addBus.carry
                     && !srcRtc_q;
      rtcIntReq_q <= state_q == ST_WCNT && memPh_q == PH_CALC && addBus.carry
                     && srcRtc_q;
    end
  end

  // grant and core lockout
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chanGrant_q  <= 1'b0;
      cpuLockout_q <= 1'b0;
    end else begin
      chanGrant_q  <= state_d == ST_GRANT;
      cpuLockout_q <= state_d inside {ST_GRANT, ST_TAKE, ST_WCNT, ST_CPTR,
                                      ST_DATA, ST_SETTLE, ST_ADDW, ST_RET};
    end
  end

  // bus data drive
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busDataOut_q <= '0;
      busDataOe_q  <= 1'b0;
    end else if (state_q == ST_DATA && memPh_q == PH_RD && memAck && dirOut_q) begin
      busDataOut_q <= memRdata;
      busDataOe_q  <= 1'b1;
    end else if (state_d == ST_RET && state_q != ST_RET) begin
      busDataOut_q <= mbr_q;
      busDataOe_q  <= 1'b1;
    end else if (state_d == ST_ET3 && state_q != ST_ET3 && cmd_q[`IOC_CMD_OUT]) begin
      busDataOut_q <= accIn;
      busDataOe_q  <= 1'b1;
    end else if (!(state_d inside {ST_DATA, ST_SETTLE, ST_RET, ST_ET3})) begin
      busDataOe_q <= 1'b0;
    end
  end

  // clock tick capture, set wins over service
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tickPrev_q <= 1'b0;
      rtcPend_q  <= 1'b0;
    end else begin
      tickPrev_q <= rtcTick;
      if (rtcEnable && rtcTick && !tickPrev_q) begin
        rtcPend_q <= 1'b1;
      end else if (state_q == ST_IDLE && state_d == ST_WCNT) begin
        rtcPend_q <= 1'b0;
      end
    end
  end

  // instruction decode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      iotPend_q <= 1'b0;
      sel_q     <= '0;
      cmd_q     <= '0;
    end else begin
      if (iotValid && iotWord[`IOC_OP_HI:`IOC_OP_LO] == `IOC_OP_VAL) begin
        iotPend_q <= 1'b1;
        sel_q     <= iotWord[`IOC_SEL_HI:`IOC_SEL_LO];
        cmd_q     <= iotWord[`IOC_CMD_HI:`IOC_CMD_LO];
      end else if (state_q == ST_IDLE && state_d == ST_ET1) begin
        iotPend_q <= 1'b0;
      end
    end
  end

  // event time pulses and accumulator traffic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      devSelect_q         <= '0;
      devSelActive_q      <= 1'b0;
      accClear_q          <= 1'b0;
      flagTestPulse_q     <= 1'b0;
      inputStrobePulse_q  <= 1'b0;
      outputStrobePulse_q <= 1'b0;
      accWrite_q          <= 1'b0;
      accData_q           <= '0;
      iotDone_q           <= 1'b0;
    end else begin
      if (state_d == ST_ET1 && state_q != ST_ET1) begin
        devSelect_q <= sel_q;
      end
      devSelActive_q      <= state_d inside {ST_ET1, ST_ET2, ST_ET3};
      accClear_q          <= state_d == ST_ET1 && state_q != ST_ET1
                             && cmd_q[`IOC_CMD_CLR];
      flagTestPulse_q     <= state_d == ST_ET1 && state_q != ST_ET1
                             && cmd_q[`IOC_CMD_FLAG];
      inputStrobePulse_q  <= state_d == ST_ET2 && state_q != ST_ET2
                             && cmd_q[`IOC_CMD_IN];
      outputStrobePulse_q <= state_d == ST_ET3 && state_q != ST_ET3
                             && cmd_q[`IOC_CMD_OUT];
      accWrite_q          <= state_q == ST_ET2 && state_d != ST_ET2
                             && cmd_q[`IOC_CMD_IN];
      if (state_q == ST_ET2 && state_d != ST_ET2) begin
        accData_q <= busDataIn;
      end
      iotDone_q <= state_q inside {ST_ET1, ST_ET2, ST_ET3} && state_d == ST_IDLE;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_settle_out: assert property (state_q == ST_DATA && state_d != ST_DATA
    && mode_q == MODE_MULTI && dirOut_q |=> state_q == ST_SETTLE && busDataOe_q)
    else $error("no settle cycle after output");
  a_cycle_len: assert property (state_q != state_d
    && state_q inside {ST_WCNT, ST_CPTR, ST_DATA, ST_ET1, ST_ET2, ST_ET3}
    |-> cyc_q == CycLast)
    else $error("processor cycle cut short");
  a_grant_free: assert property (state_q == ST_IDLE && chanReq
    |=> chanGrant_q && state_q == ST_GRANT ##1 !chanGrant_q)
    else $error("free controller did not grant");
  a_single_pass: assert property (state_q == ST_DATA && mode_q == MODE_SINGLE
    && memReq_q && memWe_q |-> memAddr_q == takenAddr_q && memWdata_q == mbr_q)
    else $error("single cycle write address altered");
  a_burst_hold: assert property (state_q != ST_IDLE && state_q != ST_GRANT
    && state_d == ST_GRANT |=> chanGrant_q && cpuLockout_q)
    else $error("burst released the core");
  a_incr_stop: assert property (state_q == ST_WCNT && state_d != ST_WCNT
    && mode_q == MODE_INCR |=> state_q inside {ST_IDLE, ST_GRANT})
    else $error("increment ran past tally cycle");
  a_add_return: assert property (state_q == ST_ADDW && state_d == ST_RET
    |=> busDataOe_q && busDataOut_q == $past(mbr_q) ##[1:40] state_q != ST_RET)
    else $error("sum not returned to device");
  a_rtc_word: assert property (state_q == ST_WCNT && srcRtc_q && memReq_q
    |-> memAddr_q == `IOC_RTC_ADDR)
    else $error("clock increments wrong word");
  a_rtc_order: assert property (state_q == ST_IDLE && rtcPend_q && !chanReq
    |=> state_q == ST_WCNT && srcRtc_q)
    else $error("clock request lost priority");
  a_input_time: assert property ($rose(inputStrobePulse_q)
    |-> state_q == ST_ET2 && $past(state_q) == ST_ET1)
    else $error("input pulse outside event time 2");
  a_skip_short: assert property (state_q == ST_ET1 && state_d != ST_ET1
    && isSkip |=> state_q == ST_IDLE && iotDone_q)
    else $error("skip ran past event time 1");
  a_ovfl_wc: assert property (ovflPulse_q
    |-> $past(state_q) == ST_WCNT && $past(memPh_q) == PH_CALC)
    else $error("overflow outside tally cycle");
  a_mem_lock: assert property (memReq_q |-> cpuLockout_q
    || state_q inside {ST_ET1, ST_ET2, ST_ET3})
    else $error("memory request without core lockout");

  c_burst: cover property (state_q == ST_DATA && state_d == ST_GRANT);
  c_add: cover property (state_q == ST_RET && busDataOe_q);
  c_skip: cover property (state_q == ST_ET1 && state_d == ST_IDLE);
  c_rtc_ovfl: cover property (rtcIntReq_q);
endmodule

// [ioc_dev_model.sv]
// Purpose: device controller model on the shared i/o bus
// Assumes: bench loads ptr, wdata and left between transfers
// Notes: released lines show the inverse of their last value
`timescale 1ns/100ps
module ioc_dev_model (
  // clock
  input  wire logic        ref_clk,
  // channel side
  output logic             chanReq,
  input  wire logic        chanGrant_q,
  output logic [17:0]      busAddrIn,
  // data lines
  output logic [17:0]      busDataIn,
  input  wire logic [17:0] busDataOut_q,
  input  wire logic        busDataOe_q,
  // addressed device
  input  wire logic [7:0]  devSelect_q,
  input  wire logic        devSelActive_q,
  input  wire logic        inputStrobePulse_q
);
  logic [17:0] left   = '0;
  logic [17:0] ptr    = '0;
  logic [17:0] wdata  = '0;
  logic [17:0] lastA  = '0;
  logic [17:0] lastD  = '0;
  logic [17:0] gotOut = '0;
  logic [17:0] inData = 18'h2D5A7;
  logic [1:0]  hold   = '0;
  logic        ans    = 1'b0;
  assign chanReq = left != '0;
  assign busAddrIn = (hold != '0) ? lastA : ~lastA;
  assign busDataIn = busDataOe_q ? busDataOut_q : (hold != '0) ? lastD : ans ? inData : ~lastD;
  always @(posedge ref_clk) begin
    hold <= (hold != '0) ? hold - 2'h1 : '0;
    if (chanGrant_q) begin
      hold  <= 2'h2;
      lastA <= ptr;
      lastD <= wdata;
      ptr   <= ptr + 18'h1;
      wdata <= wdata + 18'h1;
      left  <= left - 18'h1;
    end
    // answer only to our own select code
    if (inputStrobePulse_q && devSelect_q == 8'h2A) ans <= 1'b1;
    else if (!devSelActive_q) ans <= 1'b0;
    if (busDataOe_q) gotOut <= busDataOut_q;
  end
endmodule

// [tb_top.sv]
// Purpose: self-checking bench of the channel controller
// Assumes: memory answers one cycle after each request
// Notes: counters are cleared at the start of each sequence
`timescale 1ns/100ps
module tb_top;
  import ioc_pkg::*;
  localparam int G = 0, OV = 1, RI = 2, LK = 3, FA = 4, CL = 5, FL = 6, IN = 7, OU = 8;
  localparam int DN = 9, SE = 10, AW = 11;
  logic ref_clk, rst, chanReq, chanOut, chanGrant_q, ovflPulse_q, busDataOe_q, memReq_q;
  logic memWe_q, cpuLockout_q, rtcEnable, rtcTick, rtcIntReq_q, iotValid, devSelActive_q;
  logic accClear_q, flagTestPulse_q, inputStrobePulse_q, outputStrobePulse_q, accWrite_q;
  logic iotDone_q, lkQ, seen;
  logic               memAck = 1'b0;
  logic [17:0]        busAddrIn, busDataIn, busDataOut_q, memAddr_q, memWdata_q, memRdata;
  logic [17:0]        iotWord, accIn, accData_q, firstAddr;
  logic [17:0]        mem [0:255];
  logic [7:0]         devSelect_q;
  logic [3:0]         cmds [0:2] = '{4'hF, 4'h1, 4'h6};
  ioc_mode_t          chanMode;
  int                 cnt [0:11];
  int                 failures = 0;
  int                 n_tests = 0;
  int                 lk1, lkIn;

  ioc_channel_ctrl u_ioc_channel_ctrl (.ref_clk, .rst, .chanReq, .chanMode, .chanOut,
    .chanGrant_q, .ovflPulse_q, .busAddrIn, .busDataIn, .busDataOut_q, .busDataOe_q,
    .memReq_q, .memWe_q, .memAddr_q, .memWdata_q, .cpuLockout_q, .memAck, .memRdata,
    .rtcEnable, .rtcTick, .rtcIntReq_q, .iotValid, .iotWord, .accIn, .devSelect_q,
    .devSelActive_q, .accClear_q, .flagTestPulse_q, .inputStrobePulse_q,
    .outputStrobePulse_q, .accWrite_q, .accData_q, .iotDone_q);
  ioc_dev_model u_dev (.ref_clk, .chanReq, .chanGrant_q, .busAddrIn, .busDataIn,
    .busDataOut_q, .busDataOe_q, .devSelect_q, .devSelActive_q, .inputStrobePulse_q);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // memory model
  assign memRdata = mem[memAddr_q[7:0]];
  always @(negedge ref_clk) memAck <= memReq_q && !memAck;
  always @(posedge ref_clk) begin
    if (memReq_q && memAck && memWe_q) mem[memAddr_q[7:0]] <= memWdata_q;
    if (memReq_q && !seen) begin
      firstAddr <= memAddr_q;
      seen      <= 1'b1;
    end
    lkQ <= cpuLockout_q;
    if (!rst) begin
      cnt[G]  += int'(chanGrant_q);
      cnt[OV] += int'(ovflPulse_q);
      cnt[RI] += int'(rtcIntReq_q);
      cnt[LK] += int'(cpuLockout_q);
      cnt[FA] += int'(lkQ && !cpuLockout_q);
      cnt[CL] += int'(accClear_q);
      cnt[FL] += int'(flagTestPulse_q);
      cnt[IN] += int'(inputStrobePulse_q);
      cnt[OU] += int'(outputStrobePulse_q);
      cnt[DN] += int'(iotDone_q);
      cnt[SE] += int'(devSelActive_q);
      cnt[AW] += int'(accWrite_q);
    end
  end

  task automatic chk(string nm, logic [17:0] s, logic [17:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic idle();
    int q;
    q = 0;
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 4000 && q < 40; i++) begin
      @(negedge ref_clk);
      q = (memReq_q || cpuLockout_q || chanReq || devSelActive_q) ? 0 : q + 1;
    end
    if (q < 40) failures++;
  endtask
  task automatic clr();
    foreach (cnt[i]) cnt[i] = 0;
    seen = 1'b0;
  endtask
  task automatic chan(ioc_mode_t m, logic o, logic [17:0] a, logic [17:0] d, logic [17:0] n);
    clr();
    chanMode    = m;
    chanOut     = o;
    u_dev.ptr   = a;
    u_dev.wdata = d;
    u_dev.left  = n;
    idle();
  endtask
  task automatic io_transfer_instruction(logic [5:0] op, logic [3:0] c);
    clr();
    iotWord  = {op, 8'h2A, c};
    iotValid = 1'b1;
    @(negedge ref_clk);
    iotValid = 1'b0;
    idle();
  endtask
  task automatic tick();
    repeat (2500) @(negedge ref_clk);
    clr();
    rtcTick = 1'b1;
    idle();
    rtcTick = 1'b0;
  endtask

  initial begin
    #1000000;
    failures++;
    wrap_up();
  end
  initial begin
    rst = 1'b1; chanMode = MODE_SINGLE; chanOut = 1'b0; rtcEnable = 1'b0; rtcTick = 1'b0;
    iotValid = 1'b0; iotWord = '0; accIn = '0; seen = 1'b0; lkQ = 1'b0; firstAddr = '0;
    foreach (mem[i]) mem[i] = '0;
    clr();
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chan(MODE_SINGLE, 1'b0, 18'h00040, 18'h2ABCD, 18'h1);
    chk("single word", mem[8'h40], 18'h2ABCD);
    chk("grants", 18'(cnt[G]), 18'h1);
    chan(MODE_SINGLE, 1'b1, 18'h00040, 18'h0, 18'h1);
    chk("single out", u_dev.gotOut, 18'h2ABCD);
    lk1 = cnt[LK];
    chan(MODE_SINGLE, 1'b0, 18'h00050, 18'h00010, 18'h3);
    for (int k = 0; k < 3; k++) chk("burst word", mem[8'h50 + k], 18'h10 + 18'(k));
    chk("lockout drops", 18'(cnt[FA]), 18'h1);
    chk("burst pace", 18'(cnt[LK] - lk1 >= 50 && cnt[LK] - lk1 <= 56), 18'h1);
    mem[8'h22] = 18'h3FFFE;
    mem[8'h23] = 18'h0005F;
    chan(MODE_MULTI, 1'b0, 18'h00022, 18'h00777, 18'h1);
    chk("tally", mem[8'h22], 18'h3FFFF);
    chk("pointer", mem[8'h23], 18'h00060);
    chk("multi data", mem[8'h60], 18'h00777);
    chk("no ovfl", 18'(cnt[OV]), 18'h0);
    lkIn = cnt[LK];
    mem[8'h61] = 18'h1ABCD;
    chan(MODE_MULTI, 1'b1, 18'h00022, 18'h0, 18'h1);
    chk("tally wrap", mem[8'h22], 18'h0);
    chk("ovfl", 18'(cnt[OV]), 18'h1);
    chk("out data", u_dev.gotOut, 18'h1ABCD);
    chk("settle", 18'(cnt[LK] - lkIn), 18'h19);
    mem[8'h70] = 18'h3FFFF;
    chan(MODE_INCR, 1'b0, 18'h00070, 18'h0, 18'h1);
    chk("incr", mem[8'h70], 18'h0);
    chk("incr ovfl", 18'(cnt[OV]), 18'h1);
    mem[8'h25] = 18'h0007F;
    mem[8'h80] = 18'h00100;
    chan(MODE_ADD, 1'b0, 18'h00024, 18'h00023, 18'h1);
    chk("add word", mem[8'h80], 18'h00123);
    chk("add return", u_dev.gotOut, 18'h00123);
    rtcEnable = 1'b1;
    mem[8'h07] = 18'h3FFFF;
    tick();
    chk("clock word", mem[8'h07], 18'h0);
    chk("clock int", 18'(cnt[RI]), 18'h1);
    rtcEnable = 1'b0;
    tick();
    chk("clock off", mem[8'h07], 18'h0);
    rtcEnable = 1'b1;
    repeat (2500) @(negedge ref_clk);
    rtcTick = 1'b1;
    chan(MODE_SINGLE, 1'b0, 18'h00044, 18'h00055, 18'h1);
    rtcTick = 1'b0;
    chk("first served", firstAddr, 18'h00044);
    chk("clock later", mem[8'h07], 18'h1);
    for (int k = 0; k < 3; k++) begin
      accIn = 18'h3C3C0 + 18'(k);
      io_transfer_instruction(6'h38, cmds[k]);
      chk("select", {10'h0, devSelect_q}, 18'h0002A);
      chk("clear", 18'(cnt[CL]), 18'(cmds[k][3]));
      chk("flag", 18'(cnt[FL]), 18'(cmds[k][0]));
      chk("in", 18'(cnt[IN]), 18'(cmds[k][1]));
      chk("out", 18'(cnt[OU]), 18'(cmds[k][2]));
      chk("length", 18'(cnt[SE]), (cmds[k][2:1] == 2'h0) ? 18'h19 : 18'h4B);
      chk("done", 18'(cnt[DN]), 18'h1);
      if (cmds[k][1]) chk("acc in", accData_q, 18'h2D5A7);
      chk("acc write", 18'(cnt[AW]), 18'(cmds[k][1]));
      if (cmds[k][2]) chk("acc out", u_dev.gotOut, accIn);
    end
    io_transfer_instruction(6'h37, 4'hF);
    chk("bad opcode", 18'(cnt[DN]), 18'h0);
    // pending clock tick must not survive a reset
    rtcTick = 1'b1;
    @(negedge ref_clk);
    rst = 1'b1;
    rtcTick = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    clr();
    idle();
    chk("reset drops clock", mem[8'h07], 18'h1);
    chk("reset lockout", 18'(cnt[LK]), 18'h0);
    wrap_up();
  end
endmodule
